// file: pkg/charger_option_pkg.sv
`default_nettype none
package charger_option_pkg;

    // Byte addresses seen by the serial register port.
    localparam logic [7:0] ADDR_OPTION_LO = 8'h00;
    localparam logic [7:0] ADDR_OPTION_HI = 8'h01;
    localparam logic [7:0] ADDR_CHG_CUR_LO = 8'h02;
    localparam logic [7:0] ADDR_CHG_CUR_HI = 8'h03;
    localparam logic [7:0] ADDR_CHG_VOLT_LO = 8'h04;
    localparam logic [7:0] ADDR_CHG_VOLT_HI = 8'h05;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Value after power-on reset, both bytes.
    localparam logic [15:0] OPTION_RESET = 16'he60e;

    // Watchdog period codes.
    localparam logic [1:0] WD_CODE_OFF = 2'h0;
    localparam logic [1:0] WD_CODE_SHORT = 2'h1;
    localparam logic [1:0] WD_CODE_MID = 2'h2;
    localparam logic [1:0] WD_CODE_LONG = 2'h3;

    // Clock and time base.
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int WD_TIME_SHORT_S = 5;
    localparam int WD_TIME_MID_S = 88;
    localparam int WD_TIME_LONG_S = 175;
    localparam int WD_TICKS_SHORT = WD_TIME_SHORT_S * 1_000_000 / TICK_TIME_US;
    localparam int WD_TICKS_MID = WD_TIME_MID_S * 1_000_000 / TICK_TIME_US;
    localparam int WD_TICKS_LONG = WD_TIME_LONG_S * 1_000_000 / TICK_TIME_US;
    localparam int WD_PERIOD_W = $clog2(WD_TICKS_LONG + 1);

    // Burst floor: longest gap between bursts, rounded down.
    localparam int BURST_FLOOR_KHZ = 25;
    localparam int BURST_MAX_CYCLES = CLK_FREQ_HZ / (BURST_FLOOR_KHZ * 1000);

    typedef struct packed {
        logic low_power_select;
        logic [1:0] watchdog_period_select;
        logic input_limit_auto_clear;
        logic source_mode_flags_good;
        logic burst_floor_enable;
        logic switching_rate_select;
        logic passthrough_light_load_efficiency;
    } option_hi_t;

    typedef struct packed {
        logic reserved7;
        logic short_hiccup_disable;
        logic learn_enable;
        logic adapter_gain_select;
        logic battery_gain_select;
        logic ldo_enable;
        logic input_current_regulation_enable;
        logic charge_inhibit;
    } option_lo_t;

    typedef struct packed {
        logic ldo_on;
        logic prochot_on;
        logic monitor_on;
        logic comparator_on;
        logic adc_available;
    } gate_t;

endpackage
`default_nettype wire

// file: rtl/charge_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module charge_watchdog #(
    parameter int TICK_CYCLES = charger_option_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic [1:0] period_select,
    input wire logic restart,
    // Status
    output logic expired,
    output logic expire_pulse
);
    import charger_option_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES);

    logic [TW-1:0] tick_reg, tick_next;
    logic [WD_PERIOD_W-1:0] count_reg, count_next;
    logic expired_reg, expired_next;
    logic pulse_reg, pulse_next;

    function automatic logic [WD_PERIOD_W-1:0] ticks_for(input logic [1:0] sel);
        case (sel)
            WD_CODE_SHORT: ticks_for = WD_PERIOD_W'(WD_TICKS_SHORT);
            WD_CODE_MID: ticks_for = WD_PERIOD_W'(WD_TICKS_MID);
            default: ticks_for = WD_PERIOD_W'(WD_TICKS_LONG);
        endcase
    endfunction

    always_comb begin
        tick_next = tick_reg;
        count_next = count_reg;
        expired_next = expired_reg;
        pulse_next = 1'b0;
        if (restart || period_select == WD_CODE_OFF) begin
            tick_next = '0;
            count_next = '0;
            expired_next = 1'b0;
        end else if (!expired_reg) begin
            if (tick_reg == TW'(TICK_CYCLES - 1)) begin
                tick_next = '0;
                count_next = count_reg + 1'b1;
                if (count_reg + 1'b1 >= ticks_for(period_select)) begin
                    expired_next = 1'b1;
                    pulse_next = 1'b1;
                end
            end else begin
                tick_next = tick_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_reg <= '0;
            count_reg <= '0;
            expired_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            count_reg <= count_next;
            expired_reg <= expired_next;
            pulse_reg <= pulse_next;
        end
    end

    assign expired = expired_reg;
    assign expire_pulse = pulse_reg;

    a_wd_restart_zero: assert property (@(posedge clk) disable iff (reset)
        restart |=> (count_reg == '0 && tick_reg == '0 && !expired_reg))
        else $error("watchdog did not restart from zero");

    a_wd_expiry_cause: assert property (@(posedge clk) disable iff (reset)
        $rose(expired_reg) |-> $past(count_reg) + 1'b1 >= ticks_for($past(period_select)))
        else $error("watchdog expired early");

endmodule // charge_watchdog
`default_nettype wire

// file: rtl/charger_option_control.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The watchdog period field resets to 175 s and selects off, 5 s, 88 s or 175 s.
// - An enabled watchdog left without a charge or period write in time zeroes the charge current.
// - A charge or period write restarts an expired watchdog; charging needs valid values.
// - Low power on battery turns off the LDO, prochot, monitor buffers and ADC.
// - In low power the comparator still runs if either prochot option request bit is set.
// - With low power off on battery, prochot, monitors and comparator follow their settings.
// - With auto clear set, a falling battery presence pin clears the input limit enable.
// - With auto clear off, the battery presence pin leaves that enable untouched.
// - With the source flag set, source mode drives the supply good output high.
// - With the burst floor set, a burst is forced so the rate stays at or above 25 kHz.
// - The 16-bit option register loads E60Eh at reset.
module charger_option_control #(
    parameter int TICK_CYCLES = charger_option_pkg::TICK_CYCLES,
    parameter int BURST_MAX_CYCLES = charger_option_pkg::BURST_MAX_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Byte register port from the serial slave
    input wire logic wr_valid,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_valid,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // Pin
    input wire logic battery_presence_pin,
    // Power stage status and settings
    input wire logic battery_only,
    input wire logic source_mode_active,
    input wire logic adapter_good,
    input wire logic [1:0] prochot_comparator_req,
    input wire logic prochot_cfg_enable,
    input wire logic monitor_cfg_enable,
    input wire logic comparator_cfg_enable,
    input wire logic charge_values_valid,
    input wire logic burst_pulse,
    // Controls to the power stage
    output charger_option_pkg::option_hi_t option_hi,
    output charger_option_pkg::option_lo_t option_lo,
    output charger_option_pkg::gate_t gate,
    output logic supply_good_output,
    output logic charge_current_clear,
    output logic charge_suspend,
    output logic watchdog_expired,
    output logic burst_force
);
    import charger_option_pkg::*;

    localparam int BW = $clog2(BURST_MAX_CYCLES);

    option_hi_t hi_reg, hi_next;
    option_lo_t lo_reg, lo_next;
    logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic pin_fall;
    logic [7:0] rd_data_reg, rd_data_next;
    gate_t gate_reg, gate_next;
    logic good_reg, good_next;
    logic clear_reg, suspend_reg, expired_reg;
    logic [BW-1:0] burst_cnt_reg, burst_cnt_next;
    logic burst_force_reg, burst_force_next;
    logic wd_restart, wd_expired, wd_pulse, lp_active;

    // The strobe is passed in so that a continuous assignment also wakes on it.
    function automatic logic hit(input logic v, input logic [7:0] a, input logic [7:0] b);
        hit = v && a == b;
    endfunction

    // The first stage feeds only the second; edges are taken from the second.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else begin
            pin_meta_reg <= battery_presence_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end
    assign pin_fall = pin_prev_reg && !pin_sync_reg;

    always_comb begin
        hi_next = hi_reg;
        lo_next = lo_reg;
        rd_data_next = rd_data_reg;
        if (hit(wr_valid, wr_addr, ADDR_OPTION_HI)) begin
            hi_next = wr_data;
        end
        if (hit(wr_valid, wr_addr, ADDR_OPTION_LO)) begin
            lo_next = wr_data;
        end
        // Auto clear on pin fall.
        // The clear wins over a host write in the same cycle, so a stale enable never survives.
        // Untouched when off.
        if (hi_reg.input_limit_auto_clear && pin_fall) begin
            lo_next.input_current_regulation_enable = 1'b0;
        end
        if (rd_valid) begin
            case (rd_addr)
                ADDR_OPTION_LO: rd_data_next = lo_reg;
                ADDR_OPTION_HI: rd_data_next = hi_reg;
                default: rd_data_next = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hi_reg <= OPTION_RESET[15:8];
            lo_reg <= OPTION_RESET[7:0];
            rd_data_reg <= READ_UNMAPPED;
        end else begin
            hi_reg <= hi_next;
            lo_reg <= lo_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // Qualifying writes, which the host must repeat in time.
    assign wd_restart = hit(wr_valid, wr_addr, ADDR_CHG_CUR_LO)
        || hit(wr_valid, wr_addr, ADDR_CHG_CUR_HI)
        || hit(wr_valid, wr_addr, ADDR_CHG_VOLT_LO)
        || hit(wr_valid, wr_addr, ADDR_CHG_VOLT_HI)
        || hit(wr_valid, wr_addr, ADDR_OPTION_HI);

    charge_watchdog #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_watchdog (
        .clk(clk),
        .reset(reset),
        .period_select(hi_reg.watchdog_period_select),
        .restart(wd_restart),
        .expired(wd_expired),
        .expire_pulse(wd_pulse)
    );

    assign lp_active = hi_reg.low_power_select && battery_only;

    always_comb begin
        gate_next = '0;
        gate_next.ldo_on = lo_reg.ldo_enable && !lp_active;
        gate_next.prochot_on = prochot_cfg_enable && !lp_active;
        gate_next.monitor_on = monitor_cfg_enable && !lp_active;
        gate_next.adc_available = !lp_active;
        gate_next.comparator_on = lp_active ? |prochot_comparator_req : comparator_cfg_enable;
        good_next = adapter_good || (hi_reg.source_mode_flags_good && source_mode_active);
        burst_force_next = 1'b0;
        burst_cnt_next = burst_cnt_reg + 1'b1;
        if (burst_pulse || !hi_reg.burst_floor_enable) begin
            burst_cnt_next = '0;
        end else if (burst_cnt_reg == BW'(BURST_MAX_CYCLES - 1)) begin
            burst_cnt_next = '0;
            burst_force_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gate_reg <= '0;
            good_reg <= 1'b0;
            burst_cnt_reg <= '0;
            burst_force_reg <= 1'b0;
        end else begin
            gate_reg <= gate_next;
            good_reg <= good_next;
            burst_cnt_reg <= burst_cnt_next;
            burst_force_reg <= burst_force_next;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clear_reg <= 1'b0;
            suspend_reg <= 1'b1;
            expired_reg <= 1'b0;
        end else begin
            clear_reg <= wd_pulse;
            suspend_reg <= wd_expired || !charge_values_valid;
            expired_reg <= wd_expired;
        end
    end

    assign option_hi = hi_reg;
    assign option_lo = lo_reg;
    assign rd_data = rd_data_reg;
    assign gate = gate_reg;
    assign supply_good_output = good_reg;
    assign charge_current_clear = clear_reg;
    assign charge_suspend = suspend_reg;
    assign watchdog_expired = expired_reg;
    assign burst_force = burst_force_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_reset_value_load: assert property (
        $past(reset) |-> {hi_reg, lo_reg} == OPTION_RESET)
        else $error("option register wrong after reset");

    a_expiry_clears_current: assert property (
        wd_pulse |=> charge_current_clear ##1 !charge_current_clear)
        else $error("charge current not cleared on expiry");

    a_restart_resumes_charge: assert property (
        wd_restart && charge_values_valid ##1 charge_values_valid |=> !charge_suspend)
        else $error("charging not resumed after restart");

    a_wd_off_quiet: assert property (
        hi_reg.watchdog_period_select == WD_CODE_OFF |=> !wd_expired)
        else $error("watchdog expired while off");

    a_low_power_gates: assert property (
        lp_active |=> !gate.ldo_on && !gate.prochot_on && !gate.monitor_on && !gate.adc_available)
        else $error("low power gating missing");

    a_lp_comparator_kept: assert property (
        lp_active && |prochot_comparator_req |=> gate.comparator_on)
        else $error("comparator not kept in low power");

    a_perf_follows_cfg: assert property (
        !hi_reg.low_power_select |=> gate.prochot_on == $past(prochot_cfg_enable)
        && gate.comparator_on == $past(comparator_cfg_enable))
        else $error("performance mode ignores settings");

    a_auto_clear_acts: assert property (
        hi_reg.input_limit_auto_clear && pin_fall |=> !lo_reg.input_current_regulation_enable)
        else $error("input regulation enable not cleared");

    a_auto_clear_off: assert property (
        !hi_reg.input_limit_auto_clear && !hit(wr_valid, wr_addr, ADDR_OPTION_LO)
        |=> $stable(lo_reg))
        else $error("input regulation enable changed");

    a_source_supply_good: assert property (
        hi_reg.source_mode_flags_good && source_mode_active |=> supply_good_output)
        else $error("supply good not driven in source mode");

    a_burst_floor_gap: assert property (
        hi_reg.burst_floor_enable && burst_cnt_reg == BW'(BURST_MAX_CYCLES - 1) && !burst_pulse
        |=> burst_force)
        else $error("burst floor not enforced");

    c_expiry_seen: cover property (wd_pulse);
    c_auto_clear_seen: cover property (hi_reg.input_limit_auto_clear && pin_fall);
    c_low_power_comparator: cover property (lp_active && |prochot_comparator_req ##1 gate.comparator_on);
    c_burst_forced: cover property (burst_force);

endmodule // charger_option_control
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk,
    // Byte register port
    output var logic wr_valid,
    output var logic [7:0] wr_addr,
    output var logic [7:0] wr_data,
    output var logic rd_valid,
    output var logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial begin
        wr_valid = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        rd_valid = 1'b0;
        rd_addr = 8'h00;
    end
    // Host byte writes and reads
    // Released lines show the inverse so a stale value never passes.
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        wr_valid = 1'b1;
        wr_addr = addr;
        wr_data = data;
        @(posedge clk);
        #1;
        wr_valid = 1'b0;
        wr_addr = ~addr;
        wr_data = ~data;
    endtask
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        #1;
        rd_valid = 1'b1;
        rd_addr = addr;
        @(posedge clk);
        #1;
        rd_valid = 1'b0;
        rd_addr = ~addr;
        data = rd_data;
    endtask
endmodule // host_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import charger_option_pkg::*;
    localparam int TICK = 4;
    localparam int BURST = 16;
    localparam int LIMIT = 90000;
    logic clk, reset, wr_valid, rd_valid, pin, bat_only, src, adp_good, valid, bpulse;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, rd;
    logic [1:0] req;
    logic pc, mc, cc, good, clr, susp, expired, force_o;
    option_hi_t hi;
    option_lo_t lo;
    gate_t gate;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    int k, n;
    // Inputs hi, req, own settings, source; outputs comp, prochot, monitor, good.
    typedef struct packed {
        logic [7:0] h;
        logic [1:0] r;
        logic [2:0] cfg;
        logic s;
        logic [3:0] e;
    } row_t;
    row_t rows [5] = '{
        '{8'h84, 2'h0, 3'h7, 1'b1, 4'h0}, '{8'h84, 2'h1, 3'h7, 1'b1, 4'h8},
        '{8'h8c, 2'h2, 3'h0, 1'b1, 4'h9}, '{8'h04, 2'h0, 3'h5, 1'b1, 4'hc},
        '{8'h0c, 2'h3, 3'h2, 1'b0, 4'h2}};
    charger_option_control #(.TICK_CYCLES(TICK), .BURST_MAX_CYCLES(BURST))
        u_charger_option_control (
        .clk(clk), .reset(reset), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_data(rd_data), .battery_presence_pin(pin),
        .battery_only(bat_only), .source_mode_active(src), .adapter_good(adp_good),
        .prochot_comparator_req(req), .prochot_cfg_enable(pc), .monitor_cfg_enable(mc),
        .comparator_cfg_enable(cc), .charge_values_valid(valid), .burst_pulse(bpulse),
        .option_hi(hi), .option_lo(lo), .gate(gate), .supply_good_output(good),
        .charge_current_clear(clr), .charge_suspend(susp), .watchdog_expired(expired),
        .burst_force(force_o));
    host_model u_host_model (.clk(clk), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_data(rd_data));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Waits for expiry under a bound, then checks the clear pulse at that edge.
    task automatic wait_expiry(input int max, output int t);
        t = 0;
        while (expired !== 1'b1 && t < max) begin
            @(posedge clk);
            #1;
            t = t + 1;
        end
        check({7'h0, clr}, 8'h01);
        @(posedge clk);
        #1;
        check({7'h0, clr}, 8'h00);
    endtask
    task automatic count_force(input int every, output int cnt);
        cnt = 0;
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            #1;
            bpulse = (every > 0) && (i % every == 0);
            cnt = cnt + (force_o === 1'b1);
        end
        bpulse = 1'b0;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail = n_fail + 1;
            results();
        end
    end
    initial begin
        reset = 1'b1;
        {pin, bat_only, src, adp_good, valid, bpulse, req, pc, mc, cc} = 11'h640;
        repeat (5) @(posedge clk);
        #1;
        check(hi, 8'he6);
        check(lo, 8'h0e);
        check({3'h0, gate}, 8'h00);
        check({7'h0, susp}, 8'h01);
        reset = 1'b0;
        u_host_model.read_byte(ADDR_OPTION_HI, rd);
        check(rd, 8'he6);
        u_host_model.read_byte(ADDR_OPTION_LO, rd);
        check(rd, 8'h0e);
        u_host_model.read_byte(8'h07, rd);
        check(rd, 8'h00);
        // Gating and supply good rows, battery only, adapter absent.
        foreach (rows[i]) begin
            u_host_model.write_byte(ADDR_OPTION_HI, rows[i].h);
            {req, pc, mc, cc, src} = {rows[i].r, rows[i].cfg, rows[i].s};
            repeat (3) @(posedge clk);
            #1;
            check({4'h0, gate.comparator_on, gate.prochot_on, gate.monitor_on, good},
                  {4'h0, rows[i].e});
            if (rows[i].h[7]) begin
                check({6'h0, gate.ldo_on, gate.adc_available}, 8'h00);
            end else begin
                check({6'h0, gate.ldo_on, gate.adc_available}, 8'h03);
            end
        end
        // Battery presence fall with and without auto clear.
        u_host_model.write_byte(ADDR_OPTION_HI, 8'h94);
        pin = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check(lo, 8'h0c);
        u_host_model.write_byte(ADDR_OPTION_LO, 8'h0e);
        check(lo, 8'h0e);
        pin = 1'b1;
        u_host_model.write_byte(ADDR_OPTION_HI, 8'h84);
        pin = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check(lo, 8'h0e);
        // Burst floor on, on with real bursts, then off.
        count_force(0, n);
        check({7'h0, n >= 3 && n <= 5}, 8'h01);
        count_force(8, n);
        check(n[7:0], 8'h00);
        u_host_model.write_byte(ADDR_OPTION_HI, 8'h80);
        count_force(0, n);
        check(n[7:0], 8'h00);
        // Watchdog 5 s code: restart before expiry, expiry, restart after it.
        u_host_model.write_byte(ADDR_OPTION_HI, 8'ha6);
        repeat (19000) @(posedge clk);
        u_host_model.write_byte(ADDR_CHG_CUR_LO, 8'h10);
        repeat (19000) @(posedge clk);
        #1;
        check({7'h0, expired}, 8'h00);
        wait_expiry(1500, k);
        check({7'h0, 19000 + k >= 19997 && 19000 + k <= 20004}, 8'h01);
        check({7'h0, susp}, 8'h01);
        u_host_model.write_byte(ADDR_CHG_VOLT_HI, 8'h20);
        repeat (2) @(posedge clk);
        #1;
        check({6'h0, expired, susp}, 8'h00);
        wait_expiry(20100, k);
        check({7'h0, expired}, 8'h01);
        valid = 1'b0;
        u_host_model.write_byte(ADDR_OPTION_HI, 8'ha6);
        repeat (2) @(posedge clk);
        #1;
        check({6'h0, expired, susp}, 8'h01);
        // Reset again in mid-run, then release off battery with the adapter present.
        reset = 1'b1;
        @(posedge clk);
        #1;
        check(hi, 8'he6);
        check(lo, 8'h0e);
        check({6'h0, expired, clr}, 8'h00);
        {bat_only, adp_good} = 2'h1;
        reset = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({3'h0, gate}, 8'h15);
        check({5'h0, good, expired, susp}, 8'h05);
        u_host_model.read_byte(ADDR_OPTION_HI, rd);
        check(rd, 8'he6);
        results();
    end
endmodule // tb
`default_nettype wire
